//--- design/p2g_pkg.sv
package p2g_pkg;
	localparam int PORT_W = 8;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_LATCH = 8'h02;
	localparam logic [7:0] IDX_DIR = 8'h12;
	localparam logic [7:0] IDX_CTRL = 8'h20;
	localparam logic [11:0] ADDR_LATCH = {2'b00, IDX_LATCH, 2'b00};
	localparam logic [11:0] ADDR_DIR = {2'b00, IDX_DIR, 2'b00};
	localparam logic [11:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic CTRL_RESET = 1'b0;
	localparam int CTRL_FLOAT_SEL_BIT = 0;
	// pin positions of the forwarded peripheral inputs
	localparam int PIN_CAPTURE_LO = 0;
	localparam int PIN_CAPTURE_HI = 3;
	localparam int PIN_UPDOWN_A = 4;
	localparam int PIN_UPDOWN_B = 5;
	localparam int PIN_UPDOWN_Z = 6;
	localparam int PIN_EXT_IRQ_7 = 6;
	localparam int PIN_CONV_TRIG = 7;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ = 2'b11;
	localparam logic [1:0] HRESP_OKAY = 2'b00;
	typedef enum logic [1:0] {
		P2G_BUS_IDLE = 2'b01,
		P2G_BUS_RDWAIT = 2'b10
	} p2g_bus_state_type;
endpackage

//--- design/p2g_port2.sv
`timescale 1ns/100ps
module p2g_port2 (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic [1:0] hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_o,
	input wire logic lowpower_mode_i,
	input wire logic hw_standby_pin_n_i,
	input wire logic osc_stopped_i,
	output logic [3:0] capture_input_o,
	output logic updown_count_in_a_o,
	output logic updown_count_in_b_o,
	output logic updown_count_in_z_o,
	output logic external_irq_7_o,
	output logic converter_trigger_in_o
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic [2:0] reg_sel(input logic [31:0] addr);
		reg_sel = 3'b000;
		if (addr[11:0] == p2g_pkg::ADDR_LATCH)
			reg_sel = 3'b001;
		else if (addr[11:0] == p2g_pkg::ADDR_DIR)
			reg_sel = 3'b010;
		else if (addr[11:0] == p2g_pkg::ADDR_CTRL)
			reg_sel = 3'b100;
	endfunction

	// ----------------------------------------
	// read data select
	// ----------------------------------------
	function automatic logic [31:0] read_mux(
		input logic [2:0] sel,
		input logic [7:0] pins,
		input logic [7:0] dir,
		input logic float_sel
	);
		read_mux = 32'h00000000;
		if (sel[0])
			read_mux = {24'h000000, pins};
		else if (sel[1])
			read_mux = {24'h000000, dir};
		else if (sel[2])
			read_mux = {31'h00000000, float_sel};
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] port_output_latch;
	logic [7:0] port_direction;
	logic lowpower_pin_float_sel;
	logic [7:0] pin_fwd;
	logic standby_force;
	logic standby_pin_q;
	logic float_all;
	logic addr_ok;
	logic wr_pend;
	logic [2:0] wr_sel;
	logic [2:0] rd_sel;
	logic wr_commit;
	logic [7:0] rd_byte;
	p2g_pkg::p2g_bus_state_type bus_state;

	// ----------------------------------------
	// bus qualifiers
	// ----------------------------------------
	assign addr_ok = hsel_i & htrans_i[1] & hready_i;
	assign wr_commit = wr_pend & hready_i;
	assign rd_byte = read_mux(rd_sel, pin_fwd, port_direction, lowpower_pin_float_sel)
		[7:0];

	// ----------------------------------------
	// write address phase
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_pend <= 1'b0;
			wr_sel <= 3'b000;
		end
		else if (hready_i)
		begin
			wr_pend <= addr_ok & hwrite_i;
			wr_sel <= reg_sel(haddr_i);
		end
	end

	// ----------------------------------------
	// read sequencing, one wait state
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus_state <= p2g_pkg::P2G_BUS_IDLE;
			hreadyout_o <= 1'b1;
			hrdata_o <= 32'h00000000;
			rd_sel <= 3'b000;
		end
		else
		begin
			case (bus_state)
				p2g_pkg::P2G_BUS_IDLE:
				begin
					if (addr_ok && !hwrite_i)
					begin
						bus_state <= p2g_pkg::P2G_BUS_RDWAIT;
						hreadyout_o <= 1'b0;
						rd_sel <= reg_sel(haddr_i);
					end
				end
				p2g_pkg::P2G_BUS_RDWAIT:
				begin
					hrdata_o <= read_mux(rd_sel, pin_fwd, port_direction,
						lowpower_pin_float_sel);
					hreadyout_o <= 1'b1;
					bus_state <= p2g_pkg::P2G_BUS_IDLE;
				end
				default:
				begin
					bus_state <= p2g_pkg::P2G_BUS_IDLE;
					hreadyout_o <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// response
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			hresp_o <= p2g_pkg::HRESP_OKAY;
		else
			hresp_o <= p2g_pkg::HRESP_OKAY;
	end

	// ----------------------------------------
	// data latch
	// ----------------------------------------
	// whole byte written
	// no reset: the latch keeps its value
	always_ff @(posedge sys_clk_i)
	begin
		if (wr_commit && wr_sel[0])
			port_output_latch <= hwdata_i[7:0];
	end

	// ----------------------------------------
	// direction and float select
	// ----------------------------------------
	// direction reset value
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			port_direction <= p2g_pkg::DIR_RESET;
		else if (wr_commit && wr_sel[1])
			port_direction <= hwdata_i[7:0];
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			lowpower_pin_float_sel <= p2g_pkg::CTRL_RESET;
		else if (wr_commit && wr_sel[2])
			lowpower_pin_float_sel <= hwdata_i[p2g_pkg::CTRL_FLOAT_SEL_BIT];
	end

	// ----------------------------------------
	// hardware standby
	// ----------------------------------------
	// standby entry
	// float decided once, at the falling edge of the standby pin
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			standby_pin_q <= 1'b1;
			standby_force <= 1'b0;
		end
		else
		begin
			standby_pin_q <= hw_standby_pin_n_i;
			if (hw_standby_pin_n_i)
				standby_force <= 1'b0;
			else if (standby_pin_q)
				standby_force <= ~osc_stopped_i;
		end
	end

	assign float_all = standby_force | (lowpower_mode_i & lowpower_pin_float_sel);

	assign pin_fwd = pin_i & ~{8{standby_force}};

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// per-pin buffers
	for (genvar gi = 0; gi < p2g_pkg::PORT_W; gi++)
	begin : g_pin
		always_ff @(posedge sys_clk_i or negedge nrst_i)
		begin
			if (!nrst_i)
				pin_oe_o[gi] <= 1'b0;
			else
				pin_oe_o[gi] <= port_direction[gi] & ~float_all;
		end

		always_ff @(posedge sys_clk_i)
		begin
			pin_o[gi] <= port_output_latch[gi];
		end
	end

	// ----------------------------------------
	// peripheral input forwarding
	// ----------------------------------------
	// continuous forwarding, inputs forced to zero while standby_force is set (hardware standby entered with the oscillator running)
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			capture_input_o <= 4'h0;
			updown_count_in_a_o <= 1'b0;
			updown_count_in_b_o <= 1'b0;
			updown_count_in_z_o <= 1'b0;
			external_irq_7_o <= 1'b0;
			converter_trigger_in_o <= 1'b0;
		end
		else
		begin
			capture_input_o <= pin_fwd[p2g_pkg::PIN_CAPTURE_HI:p2g_pkg::PIN_CAPTURE_LO];
			updown_count_in_a_o <= pin_fwd[p2g_pkg::PIN_UPDOWN_A];
			updown_count_in_b_o <= pin_fwd[p2g_pkg::PIN_UPDOWN_B];
			updown_count_in_z_o <= pin_fwd[p2g_pkg::PIN_UPDOWN_Z];
			external_irq_7_o <= pin_fwd[p2g_pkg::PIN_EXT_IRQ_7];
			converter_trigger_in_o <= pin_fwd[p2g_pkg::PIN_CONV_TRIG];
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence rd_accept_s;
		hsel_i && htrans_i[1] && hready_i && !hwrite_i;
	endsequence

	sequence rd_answer_s;
		!hreadyout_o ##1 hreadyout_o;
	endsequence

	oe_follow_a: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		pin_oe_o == ($past(port_direction) & ~{8{$past(float_all)}}))
		else $error("pin enable does not follow direction");

	pin_drive_a: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(|pin_oe_o) |-> ((pin_o & pin_oe_o) == ($past(port_output_latch) & pin_oe_o)))
		else $error("driven pin differs from latch");

	rd_wait_a: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		rd_accept_s |=> rd_answer_s)
		else $error("read answer not after one wait");

	rd_data_a: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		rd_accept_s |=> ##1 (hrdata_o[7:0] == $past(rd_byte)))
		else $error("read data wrong");

	latch_write_a: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(wr_commit && wr_sel[0]) |=> (port_output_latch == $past(hwdata_i[7:0])))
		else $error("latch write lost");

	fwd_cap_a: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		capture_input_o == $past(pin_fwd[3:0]))
		else $error("capture input not forwarded");

	standby_off_a: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		standby_force |=> (pin_oe_o == 8'h00))
		else $error("buffers on in standby");

	osc_stop_a: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(standby_pin_q && !hw_standby_pin_n_i && osc_stopped_i) |=> !standby_force)
		else $error("standby floated with oscillator stopped");
endmodule

//--- tb/p2g_brd.sv
`timescale 1ns/100ps
module p2g_brd (
	input wire logic [7:0] d_i,
	input wire logic [7:0] e_i,
	input wire logic [7:0] x_i,
	output logic [7:0] p_o);
	assign p_o = d_i & e_i | x_i & ~e_i;
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
	logic c = 0, n = 0, w = 0, t = 0, y, lp = 0, sb = 1, os = 0;
	wire [1:0] r;
	wire [8:0] f;
	function automatic [8:0] fwd(input [7:0] p);
		fwd = {p[3:0], p[4], p[5], p[6], p[6], p[7]};
	endfunction
	logic [31:0] a = 0, d = 0, q; logic [7:0] po, oe, pi, x = 0, l, m;
	int n_mismatch = 0, compares = 0; always #10 c = ~c;
	p2g_port2 u_p2g_port2 (.sys_clk_i(c), .nrst_i(n), .hsel_i(1'b1), .haddr_i(a), .htrans_i({t, 1'b0}),
		.hwrite_i(w), .hsize_i(3'h2), .hwdata_i(d), .hready_i(y), .hreadyout_o(y), .hresp_o(r),
		.hrdata_o(q), .pin_i(pi), .pin_o(po), .pin_oe_o(oe), .lowpower_mode_i(lp),
		.hw_standby_pin_n_i(sb), .osc_stopped_i(os), .capture_input_o(f[8:5]),
		.external_irq_7_o(f[1]), .updown_count_in_a_o(f[4]), .updown_count_in_b_o(f[3]),
		.updown_count_in_z_o(f[2]), .converter_trigger_in_o(f[0]));
	p2g_brd u_p2g_brd (.d_i(po), .e_i(oe), .x_i(x), .p_o(pi));
	task end_sim(input int f); n_mismatch += f;
		if (!n_mismatch && compares) $display("TEST PASSED"); else $display("TEST FAILED");
		$finish; endtask
	task chk(input string s, input [15:0] g, e); compares++; n_mismatch += g !== e;
		if (g !== e) $display("[ERR] %s %h %h", s, e, g); endtask
	task wt; do @(posedge c); while (y !== 1'b1); endtask
	task bus(input h, input [11:0] b, input [31:0] v);
		{t, w, a, d} <= {1'b1, h, 20'h0, b, v}; wt;
		t <= 0; wt; endtask
	initial #1e5 end_sim(1);
	initial
	begin
		void'($urandom(45)); repeat (20) @(posedge c); n <= 1;
		chk("oe", oe, 0);
		repeat (40)
		begin
			{l, m} = 16'($urandom); x <= 8'($urandom);
			bus(1, p2g_pkg::ADDR_LATCH, l); bus(1, p2g_pkg::ADDR_DIR, m);
			bus(0, p2g_pkg::ADDR_LATCH, 0);
			chk("rd", {oe, q[7:0]}, {m, l & m | x & ~m});
			chk("fwd", f, fwd(pi));
			chk("resp", r, 0);
		end
		bus(1, p2g_pkg::ADDR_CTRL, 1); lp <= 1; repeat (3) @(posedge c);
		chk("lp", oe, 0);
		lp <= 0; sb <= 0; repeat (3) @(posedge c);
		chk("hst", oe, 0);
		sb <= 1; os <= 1; repeat (2) @(posedge c); sb <= 0; repeat (3) @(posedge c);
		chk("osc", oe, m);
		end_sim(0);
	end
endmodule
